// ===== oes_pkg.sv
// constants for the output offset/expand scaler
package oes_pkg;

  // register byte offsets
  localparam logic [7:0] OES_REG_CTRL   = 8'h00;
  localparam logic [7:0] OES_REG_OFS_X  = 8'h04;
  localparam logic [7:0] OES_REG_OFS_Y  = 8'h08;
  localparam logic [7:0] OES_REG_OFS_R  = 8'h0c;
  localparam logic [7:0] OES_REG_SENS   = 8'h10;
  localparam logic [7:0] OES_REG_STATUS = 8'h14;
  localparam logic [7:0] OES_REG_MASK   = 8'h18;
  localparam logic [7:0] OES_REG_OUT    = 8'h1c;
  localparam logic [7:0] OES_REG_FLAGS  = 8'h20;
  localparam logic [7:0] OES_REG_CMD    = 8'h24;
  localparam logic [7:0] OES_REG_SINE   = 8'h28;

  // offset register fields
  localparam int OES_PCT_W     = 11;
  localparam int OES_OFS_EN    = 16;
  localparam int OES_EXP_LSB   = 17;
  localparam int OES_RATIO_BIT = 19;

  // ctrl, cmd, status and sine fields
  localparam int OES_CTRL_SEL  = 0;
  localparam int OES_CMD_AUTO  = 0;
  localparam int OES_CMD_EXP   = 1;
  localparam int OES_CMD_OFS   = 2;
  localparam int OES_CMD_SEL   = 3;
  localparam int OES_ST_OVLD   = 0;
  localparam int OES_ST_AUTO   = 1;
  localparam int OES_ST_W      = 2;
  localparam int OES_SINE_W    = 16;
  localparam int OES_SINE_REF  = 16;

  // key bit positions
  localparam int OES_KEY_SEL   = 0;
  localparam int OES_KEY_EXP   = 1;
  localparam int OES_KEY_OFS   = 2;
  localparam int OES_KEY_AUTO  = 3;
  localparam int OES_NKEY      = 4;

  // quantity indices
  localparam int OES_Q_X       = 0;
  localparam int OES_Q_Y       = 1;
  localparam int OES_Q_R       = 2;
  localparam int OES_NQ        = 3;

  // expand codes
  localparam logic [1:0] OES_EXP_X1   = 2'h0;
  localparam logic [1:0] OES_EXP_X10  = 2'h1;
  localparam logic [1:0] OES_EXP_X100 = 2'h2;

  // scaling constants
  localparam int OES_FS_VOLTS  = 10;
  localparam int OES_FS_MV     = OES_FS_VOLTS * 1000;
  localparam int OES_PCT_SCALE = 100;
  localparam int OES_PCT_MAX   = 999;
  localparam int OES_MV_W      = 16;

  // reset values
  localparam logic [15:0] OES_SINE_RST = 16'h0000;

  typedef enum logic [1:0] {
    OES_IDLE,
    OES_DIV,
    OES_DONE
  } oes_state_t;

endpackage : oes_pkg

// ===== oes_scaler.sv
// output offset/expand scaler with apb registers
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
module oes_scaler #(
  parameter int          DW       = 24,
  parameter logic [23:0] SENS_RST = 24'hf4240
) (
  input  wire logic                        i_ref_clk,
  input  wire logic                        i_nrst,
  input  wire logic                        i_psel,
  input  wire logic                        i_penable,
  input  wire logic                        i_pwrite,
  input  wire logic [7:0]                  i_paddr,
  input  wire logic [31:0]                 i_pwdata,
  output logic                             o_pready,
  output logic [31:0]                      o_prdata,
  output logic                             o_pslverr,
  input  wire logic signed [DW-1:0]        i_x,
  input  wire logic signed [DW-1:0]        i_y,
  input  wire logic signed [DW-1:0]        i_r,
  input  wire logic [oes_pkg::OES_NKEY-1:0] i_key,
  output logic signed [DW-1:0]             o_x_val,
  output logic signed [DW-1:0]             o_y_val,
  output logic signed [DW-1:0]             o_r_val,
  output logic signed [oes_pkg::OES_MV_W-1:0] o_channel_one_output,
  output logic                             o_channel_sel,
  output logic                             o_overload_led,
  output logic                             o_scale_overload,
  output logic [oes_pkg::OES_NQ-1:0]       o_expd,
  output logic [oes_pkg::OES_NQ-1:0]       o_ofst,
  output logic                             o_offset_led,
  output logic [oes_pkg::OES_SINE_W-1:0]   o_sine_ampl,
  output logic                             o_ref_internal,
  output logic                             o_irq
);
  import oes_pkg::*;

  localparam int NW = DW + 20;
  localparam int CW = 6;
  localparam int PW = OES_PCT_W;

  if (DW < 8 || DW > 32 || NW > 63) begin : g_dw_chk
    $error("oes_scaler: DW must be 8..32");
  end

  typedef struct packed {
    oes_state_t               st;
    logic                     job_auto;
    logic                     neg;
    logic [1:0]               job_q;
    logic [CW-1:0]            cnt;
    logic [NW-1:0]            num;
    logic [NW-1:0]            quo;
    logic [DW:0]              rem;
    logic                     sel;
    logic [DW-1:0]            sens;
    logic [OES_NQ-1:0][PW-1:0] pct;
    logic [OES_NQ-1:0]        ofs_en;
    logic [OES_NQ-1:0]        ratio;
    logic [OES_NQ-1:0][1:0]   expc;
    logic [OES_NQ-1:0][DW-1:0] val;
    logic [OES_MV_W-1:0]      mv;
    logic                     ovld;
    logic                     auto_pend;
    logic [OES_ST_W-1:0]      sts;
    logic [OES_ST_W-1:0]      msk;
    logic [OES_SINE_W-1:0]    sine;
    logic                     ref_int;
    logic [31:0]              rdata;
    logic                     slverr;
    logic [OES_NKEY-1:0]      s1;
    logic [OES_NKEY-1:0]      s2;
    logic [OES_NKEY-1:0]      s3;
    logic [OES_NKEY-1:0]      stab;
  } oes_regs_t;

  oes_regs_t s;
  oes_regs_t next_s;

  // offset amount in quantity units: pct * sens / 100
  function automatic logic signed [DW+PW:0] ofs_amt(
    input logic [PW-1:0] pct,
    input logic [DW-1:0] sens
  );
    logic signed [DW+PW:0] prod;
    prod = $signed(pct) * $signed({1'b0, sens});
    ofs_amt = prod / $signed((DW+PW+1)'(OES_PCT_SCALE));
  endfunction : ofs_amt

  // saturate a wide signed value into the quantity width
  function automatic logic [DW-1:0] sat_q(input logic signed [DW+PW+1:0] v);
    logic signed [DW+PW+1:0] hi;
    logic signed [DW+PW+1:0] lo;
    hi = (DW+PW+2)'((64'sd1 <<< (DW-1)) - 64'sd1);
    lo = -hi - (DW+PW+2)'(1);
    if (v > hi) begin
      sat_q = DW'(hi);
    end else if (v < lo) begin
      sat_q = DW'(lo);
    end else begin
      sat_q = DW'(v);
    end
  endfunction : sat_q

  // expand factor as a multiplier
  function automatic logic [NW-1:0] exp_mul(input logic [1:0] c);
    case (c)
      OES_EXP_X10:  exp_mul = NW'(10);
      OES_EXP_X100: exp_mul = NW'(100);
      default:      exp_mul = NW'(1);
    endcase
  endfunction : exp_mul

  // magnitude of a signed quantity
  function automatic logic [DW-1:0] mag(input logic [DW-1:0] v);
    mag = v[DW-1] ? DW'(-$signed(v)) : v;
  endfunction : mag

  logic [OES_NQ-1:0][DW-1:0] raw;
  logic [OES_NQ-1:0][DW-1:0] corr;
  logic [OES_NKEY-1:0]       press;
  logic                      wr;
  logic                      rd_setup;
  logic [1:0]                qi;
  logic                      do_sel;
  logic                      do_exp;
  logic                      do_ofs;
  logic                      do_auto;
  logic [DW:0]               trial;
  logic [NW-1:0]             lim;
  logic [31:0]               rd;
  logic                      rd_ok;
  logic [OES_NQ-1:0]         ofs_we;
  logic [PW-1:0]             wpct;
  logic [OES_ST_W-1:0]       ev;

  always_comb begin
    next_s   = s;
    raw[OES_Q_X] = i_x;
    raw[OES_Q_Y] = i_y;
    raw[OES_Q_R] = i_r;
    wr       = i_psel && i_penable && i_pwrite;
    rd_setup = i_psel && !i_penable;
    qi       = s.sel ? 2'(OES_Q_R) : 2'(OES_Q_X);
    ev       = '0;
    trial    = '0;
    lim      = '0;
    wpct     = '0;
    ofs_we   = '0;

    // key synchroniser: a change counts once stages two and three agree
    next_s.s1 = i_key;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    for (int k = 0; k < OES_NKEY; k++) begin
      if (s.s2[k] == s.s3[k]) begin
        next_s.stab[k] = s.s2[k];
      end
      press[k] = s.s2[k] && s.s3[k] && !s.stab[k];
    end

    do_sel  = press[OES_KEY_SEL]
              || (wr && i_paddr == OES_REG_CMD && i_pwdata[OES_CMD_SEL]);
    do_exp  = press[OES_KEY_EXP]
              || (wr && i_paddr == OES_REG_CMD && i_pwdata[OES_CMD_EXP]);
    do_ofs  = press[OES_KEY_OFS]
              || (wr && i_paddr == OES_REG_CMD && i_pwdata[OES_CMD_OFS]);
    do_auto = press[OES_KEY_AUTO]
              || (wr && i_paddr == OES_REG_CMD && i_pwdata[OES_CMD_AUTO]);

    // offset-corrected values; sensitivity scales the offset amount and the output
    for (int q = 0; q < OES_NQ; q++) begin
      if (s.ofs_en[q]) begin
        corr[q] = sat_q($signed(raw[q]) - ofs_amt(s.pct[q], s.sens));
      end else begin
        corr[q] = raw[q];
      end
      next_s.val[q] = corr[q];
    end

    // register writes
    if (wr) begin
      if (i_paddr == OES_REG_CTRL) begin
        next_s.sel = i_pwdata[OES_CTRL_SEL];
      end else if (i_paddr == OES_REG_OFS_X) begin
        ofs_we[OES_Q_X] = 1'b1;
      end else if (i_paddr == OES_REG_OFS_Y) begin
        ofs_we[OES_Q_Y] = 1'b1;
      end else if (i_paddr == OES_REG_OFS_R) begin
        ofs_we[OES_Q_R] = 1'b1;
      end else if (i_paddr == OES_REG_SENS) begin
        if (i_pwdata[DW-1:0] != '0) begin
          next_s.sens = i_pwdata[DW-1:0];
        end
      end else if (i_paddr == OES_REG_MASK) begin
        next_s.msk = i_pwdata[OES_ST_W-1:0];
      end else if (i_paddr == OES_REG_SINE) begin
        next_s.sine    = i_pwdata[OES_SINE_W-1:0];
        next_s.ref_int = i_pwdata[OES_SINE_REF];
      end
    end
    // offset written as percent, clamped to +/-999
    wpct = i_pwdata[PW-1:0];
    if ($signed(wpct) > $signed(PW'(OES_PCT_MAX))) begin
      wpct = PW'(OES_PCT_MAX);
    end else if ($signed(wpct) < -$signed(PW'(OES_PCT_MAX))) begin
      wpct = PW'(-OES_PCT_MAX);
    end
    for (int q = 0; q < OES_NQ; q++) begin
      if (ofs_we[q]) begin
        next_s.pct[q]    = wpct;
        next_s.ofs_en[q] = i_pwdata[OES_OFS_EN];
        next_s.ratio[q]  = i_pwdata[OES_RATIO_BIT];
        if (i_pwdata[OES_EXP_LSB +: 2] <= OES_EXP_X100) begin
          next_s.expc[q] = i_pwdata[OES_EXP_LSB +: 2];
        end
      end
    end

    // front panel actions on the selected quantity
    if (do_sel) begin
      next_s.sel = !s.sel;
    end
    if (do_ofs) begin
      next_s.ofs_en[qi] = !s.ofs_en[qi];
    end
    if (do_exp) begin
      case (s.expc[qi])
        OES_EXP_X1:  next_s.expc[qi] = OES_EXP_X10;
        OES_EXP_X10: next_s.expc[qi] = OES_EXP_X100;
        default:     next_s.expc[qi] = OES_EXP_X1;
      endcase
    end

    // shared divider: output scaling or auto offset
    case (s.st)
      OES_IDLE: begin
        next_s.rem   = '0;
        next_s.quo   = '0;
        next_s.cnt   = CW'(NW - 1);
        next_s.job_q = qi;
        next_s.st    = OES_DIV;
        if (s.auto_pend) begin
          next_s.job_auto = 1'b1;
          next_s.neg      = raw[qi][DW-1];
          next_s.num      = NW'(mag(raw[qi])) * NW'(OES_PCT_SCALE);
        end else begin
          next_s.job_auto = 1'b0;
          next_s.neg      = corr[qi][DW-1];
          next_s.num      = NW'(mag(corr[qi])) * NW'(OES_FS_MV)
                            * exp_mul(s.expc[qi]);
        end
      end
      OES_DIV: begin
        trial        = {s.rem[DW-1:0], s.num[NW-1]};
        next_s.num   = {s.num[NW-2:0], 1'b0};
        if (trial >= {1'b0, s.sens}) begin
          next_s.rem = trial - {1'b0, s.sens};
          next_s.quo = {s.quo[NW-2:0], 1'b1};
        end else begin
          next_s.rem = trial;
          next_s.quo = {s.quo[NW-2:0], 1'b0};
        end
        if (s.cnt == '0) begin
          next_s.st = OES_DONE;
        end else begin
          next_s.cnt = s.cnt - CW'(1);
        end
      end
      OES_DONE: begin
        next_s.st = OES_IDLE;
        if (s.job_auto) begin
          lim = (s.quo > NW'(OES_PCT_MAX)) ? NW'(OES_PCT_MAX) : s.quo;
          next_s.pct[s.job_q] = s.neg ? PW'(-$signed(PW'(lim)))
                                      : PW'(lim);
          next_s.ofs_en[s.job_q] = 1'b1;
          next_s.auto_pend       = 1'b0;
          ev[OES_ST_AUTO]        = 1'b1;
        end else begin
          if (s.quo > NW'(OES_FS_MV)) begin
            lim         = NW'(OES_FS_MV);
            next_s.ovld = 1'b1;
          end else begin
            lim         = s.quo;
            next_s.ovld = 1'b0;
          end
          next_s.mv = s.neg ? OES_MV_W'(-$signed(OES_MV_W'(lim)))
                            : OES_MV_W'(lim);
          ev[OES_ST_OVLD] = next_s.ovld;
        end
      end
      default: begin
        next_s.st = OES_IDLE;
      end
    endcase
    // a request in the completion cycle is kept
    if (do_auto) begin
      next_s.auto_pend = 1'b1;
    end

    // sticky status: write one clears, a new event wins
    if (wr && i_paddr == OES_REG_STATUS) begin
      next_s.sts = s.sts & ~i_pwdata[OES_ST_W-1:0];
    end
    next_s.sts = next_s.sts | ev;

    // read data captured in the setup phase
    rd    = '0;
    rd_ok = 1'b1;
    if (i_paddr == OES_REG_CTRL) begin
      rd[OES_CTRL_SEL] = s.sel;
    end else if (i_paddr == OES_REG_OFS_X || i_paddr == OES_REG_OFS_Y
                 || i_paddr == OES_REG_OFS_R) begin
      rd[PW-1:0]               = s.pct[i_paddr[3:2] - 2'h1];
      rd[OES_OFS_EN]           = s.ofs_en[i_paddr[3:2] - 2'h1];
      rd[OES_EXP_LSB +: 2]     = s.expc[i_paddr[3:2] - 2'h1];
      rd[OES_RATIO_BIT]        = s.ratio[i_paddr[3:2] - 2'h1];
    end else if (i_paddr == OES_REG_SENS) begin
      rd[DW-1:0] = s.sens;
    end else if (i_paddr == OES_REG_STATUS) begin
      rd[OES_ST_W-1:0] = s.sts;
    end else if (i_paddr == OES_REG_MASK) begin
      rd[OES_ST_W-1:0] = s.msk;
    end else if (i_paddr == OES_REG_OUT) begin
      rd = 32'($signed(s.mv));
    end else if (i_paddr == OES_REG_FLAGS) begin
      for (int q = 0; q < OES_NQ; q++) begin
        rd[q]          = s.expc[q] != OES_EXP_X1;
        rd[OES_NQ + q] = s.ofs_en[q];
      end
      rd[2*OES_NQ] = s.ovld;
    end else if (i_paddr == OES_REG_SINE) begin
      rd[OES_SINE_W-1:0] = s.sine;
      rd[OES_SINE_REF]   = s.ref_int;
    end else if (i_paddr == OES_REG_CMD) begin
      rd = '0;
    end else begin
      rd_ok = 1'b0;
    end
    if (rd_setup) begin
      next_s.rdata  = rd;
      next_s.slverr = !rd_ok;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      s          <= '0;
      s.st       <= OES_IDLE;
      s.sel      <= 1'b0;
      s.sens     <= DW'(SENS_RST);
      s.sine     <= OES_SINE_RST;
      s.ref_int  <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign o_pready             = 1'b1;
  assign o_prdata             = s.rdata;
  assign o_pslverr            = s.slverr;
  assign o_x_val              = s.val[OES_Q_X];
  assign o_y_val              = s.val[OES_Q_Y];
  assign o_r_val              = s.val[OES_Q_R];
  assign o_channel_one_output = s.mv;
  assign o_channel_sel        = s.sel;
  assign o_overload_led       = s.ovld;
  assign o_scale_overload     = s.ovld;
  assign o_sine_ampl          = s.sine;
  assign o_ref_internal       = s.ref_int;
  assign o_irq                = |(s.sts & s.msk);
  assign o_offset_led         = s.ofs_en[s.sel ? OES_Q_R : OES_Q_X];

  always_comb begin
    for (int q = 0; q < OES_NQ; q++) begin
      o_expd[q] = s.expc[q] != OES_EXP_X1;
      o_ofst[q] = s.ofs_en[q];
    end
  end

endmodule : oes_scaler

// ===== oes_scaler_props.sv
// assertions for the output offset/expand scaler
module oes_scaler_props #(
  parameter int DW = 24
) (
  input wire logic                             i_ref_clk,
  input wire logic                             i_nrst,
  input wire logic signed [DW-1:0]             i_x,
  input wire logic signed [DW-1:0]             i_y,
  input wire logic                             o_pready,
  input wire logic signed [DW-1:0]             o_x_val,
  input wire logic signed [DW-1:0]             o_y_val,
  input wire logic signed [oes_pkg::OES_MV_W-1:0] o_channel_one_output,
  input wire logic                             o_channel_sel,
  input wire logic                             o_overload_led,
  input wire logic                             o_scale_overload,
  input wire logic [oes_pkg::OES_NQ-1:0]       o_ofst,
  input wire logic                             o_offset_led,
  input wire logic [oes_pkg::OES_SINE_W-1:0]   o_sine_ampl,
  input wire logic                             o_ref_internal
);
  import oes_pkg::*;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  a_ready_always: assert property (o_pready)
    else $error("pready dropped");
  a_out_range: assert property (o_channel_one_output <= 16'sd10000 &&
    o_channel_one_output >= -16'sd10000) else $error("output out of range");
  a_ovld_clamp: assert property (o_overload_led |->
    (o_channel_one_output == 16'sd10000 || o_channel_one_output == -16'sd10000))
    else $error("overload without clamp");
  a_ovld_pair: assert property (o_overload_led == o_scale_overload)
    else $error("overload flags disagree");
  a_led_follow: assert property (($stable(o_ofst) && $stable(o_channel_sel))[*2]
    |-> o_offset_led == (o_channel_sel ? o_ofst[OES_Q_R] : o_ofst[OES_Q_X]))
    else $error("offset led wrong");
  a_reset_dflt: assert property ($rose(i_nrst) |-> o_ref_internal &&
    o_sine_ampl == 16'h0000 && !o_channel_sel) else $error("bad defaults");
  a_xval_pass: assert property ($past(!o_ofst[OES_Q_X]) && $past(i_nrst)
    |-> o_x_val == $past(i_x)) else $error("x value altered");
  a_yval_pass: assert property ($past(!o_ofst[OES_Q_Y]) && $past(i_nrst)
    |-> o_y_val == $past(i_y)) else $error("y value altered");
  a_out_steady: assert property ($changed(o_channel_one_output)
    |=> $stable(o_channel_one_output)[*8]) else $error("output too busy");
  c_neg_clamp: cover property (o_overload_led && o_channel_one_output < 0);
  c_sel_r: cover property (o_channel_sel && !o_offset_led);
  c_ofs_on: cover property ($rose(o_ofst[OES_Q_X]));
endmodule : oes_scaler_props

bind oes_scaler oes_scaler_props #(.DW(DW)) i_props (.i_ref_clk, .i_nrst, .i_x,
  .i_y, .o_pready, .o_x_val, .o_y_val, .o_channel_one_output, .o_channel_sel,
  .o_overload_led, .o_scale_overload, .o_ofst, .o_offset_led, .o_sine_ampl,
  .o_ref_internal);

// ===== oes_panel.sv
// front panel model: holds each key long enough for the synchroniser
module oes_panel (
  input  wire logic                         i_ref_clk,
  output logic [oes_pkg::OES_NKEY-1:0]      o_key
);
  timeunit 1ns;
  timeprecision 1ps;
  import oes_pkg::*;
  initial o_key = '0;
  task automatic press(input int k);
    o_key[k] <= 1'b1;
    repeat (8) @(posedge i_ref_clk);
    o_key[k] <= 1'b0;
    repeat (8) @(posedge i_ref_clk);
  endtask : press
endmodule : oes_panel

// ===== oes_scaler_tb.sv
// testbench for the output offset/expand scaler
module oes_scaler_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import oes_pkg::*;
  logic               i_ref_clk, i_nrst, i_psel, i_penable, i_pwrite;
  logic        [7:0]  i_paddr;
  logic        [31:0] i_pwdata, o_prdata, rd;
  logic               o_pready, o_pslverr, err, o_channel_sel, o_irq;
  logic               o_overload_led, o_scale_overload, o_offset_led;
  logic               o_ref_internal;
  logic signed [23:0] i_x, i_y, i_r, o_x_val, o_y_val, o_r_val;
  logic signed [15:0] o_channel_one_output;
  logic        [3:0]  i_key;
  logic        [2:0]  o_expd, o_ofst;
  logic        [15:0] o_sine_ampl;
  int                 num_errors, n_tests, cyc;
  int                 exps[3] = '{10, 100, 1};

  oes_scaler i_dut (.i_ref_clk, .i_nrst, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .i_pwdata, .o_pready, .o_prdata, .o_pslverr, .i_x, .i_y, .i_r,
    .i_key, .o_x_val, .o_y_val, .o_r_val, .o_channel_one_output,
    .o_channel_sel, .o_overload_led, .o_scale_overload, .o_expd, .o_ofst,
    .o_offset_led, .o_sine_ampl, .o_ref_internal, .o_irq);
  oes_panel i_panel (.i_ref_clk, .o_key(i_key));

  initial begin
    i_ref_clk = 1'b0;
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    i_psel <= 1'b1;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_ref_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_ref_clk);
    end while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_ref_clk);
  endtask : apb

  function automatic logic [31:0] mv(longint q, pct, en, ex, sens);
    longint d, v;
    d = q - en * pct * sens / 100;
    v = (d < 0 ? -d : d) * 10000 * ex / sens;
    if (v > 10000) v = 10000;
    return 32'(d < 0 ? -v : v);
  endfunction : mv

  task automatic settle();
    repeat (150) @(posedge i_ref_clk);
  endtask : settle

  initial begin
    {i_nrst, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = '0;
    {i_x, i_y, i_r, num_errors, n_tests, cyc} = '0;
    repeat (8) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    i_x <= 24'sd100000;
    i_y <= 24'sd7;
    i_r <= 24'sd50000;
    @(posedge i_ref_clk);
    apb(0, OES_REG_SINE, 0); chk(rd, 32'h0001_0000);
    apb(0, OES_REG_CTRL, 0); chk(rd, 32'h0);
    apb(0, OES_REG_SENS, 0); chk(rd, 32'h000f_4240);
    apb(0, 8'h30, 0); chk(32'(err), 32'h1);
    chk({o_sine_ampl, o_ref_internal}, 32'h1);
    settle(); chk(32'(o_channel_one_output), mv(100000, 0, 0, 1, 1000000));
    apb(1, OES_REG_SENS, 32'h0007_a120);
    settle(); chk(32'(o_channel_one_output), 32'd2000);
    chk(32'(o_x_val), 32'd100000);
    chk(32'(o_y_val), 32'd7);
    chk(32'(o_r_val), 32'd50000);
    apb(1, OES_REG_SENS, 32'h0001_86a0);
    settle(); chk(32'(o_channel_one_output), 32'd10000);
    chk(32'(o_overload_led), 32'h0);
    apb(1, OES_REG_MASK, 32'h2);
    apb(1, OES_REG_CMD, 32'h1);
    settle(); apb(0, OES_REG_OFS_X, 0); chk(rd, 32'h0001_0064);
    chk(32'(o_channel_one_output), 32'h0);
    chk(32'(o_x_val), 32'h0);
    chk(32'(o_irq), 32'h1);
    apb(1, OES_REG_STATUS, 32'h2); chk(32'(o_irq), 32'h0);
    apb(1, OES_REG_OFS_X, 32'h0001_005a);
    settle(); chk(32'(o_channel_one_output), mv(100000, 90, 1, 1, 100000));
    chk(32'(o_x_val), 32'd10000);
    chk({o_offset_led, o_ofst}, 32'h9);
    i_panel.press(OES_KEY_OFS);
    settle(); chk(32'(o_channel_one_output), 32'd10000);
    apb(0, OES_REG_OFS_X, 0); chk(rd, 32'h0000_005a);
    chk(32'(o_offset_led), 32'h0);
    i_panel.press(OES_KEY_OFS);
    for (int i = 0; i < 3; i++) begin
      i_panel.press(OES_KEY_EXP);
      settle(); chk(32'(o_channel_one_output), mv(100000, 90, 1, exps[i], 100000));
      chk({o_overload_led, o_scale_overload}, 32'(i == 1 ? 3 : 0));
      chk(32'(o_expd), 32'(i < 2));
      chk(32'(o_x_val), 32'd10000);
    end
    apb(1, OES_REG_CMD, 32'h2);
    chk(32'(o_expd), 32'h1);
    apb(1, OES_REG_CMD, 32'h4);
    chk(32'(o_offset_led), 32'h0);
    i_x <= -24'sd100000;
    apb(1, OES_REG_OFS_X, 32'h0005_005a);
    settle(); chk(32'(o_channel_one_output), mv(-100000, 90, 1, 100, 100000));
    chk(32'(o_overload_led), 32'h1);
    i_panel.press(OES_KEY_SEL);
    settle(); chk(32'(o_channel_sel), 32'h1);
    chk(32'(o_channel_one_output), mv(50000, 0, 0, 1, 100000));
    chk({o_offset_led, o_ofst}, 32'h1);
    apb(1, OES_REG_CMD, 32'h8);
    settle(); chk(32'(o_channel_sel), 32'h0);
    apb(1, OES_REG_OFS_Y, 32'h0000_03e8);
    apb(0, OES_REG_OFS_Y, 0); chk(rd, 32'h0000_03e7);
    apb(1, OES_REG_OFS_R, 32'h000e_0000);
    apb(0, OES_REG_OFS_R, 0);
    chk(rd, 32'h0008_0000);
    i_panel.press(OES_KEY_AUTO);
    settle();
    chk(32'(o_x_val), 32'h0);
    apb(0, OES_REG_OFS_X, 0);
    chk(rd, 32'h0005_079c);
    apb(1, OES_REG_SINE, 32'h0000_1234);
    apb(1, OES_REG_CTRL, 32'h1);
    chk({o_sine_ampl, o_ref_internal, o_channel_sel}, 32'h48d1);
    i_nrst <= 1'b0;
    repeat (8) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    @(posedge i_ref_clk);
    chk({o_sine_ampl, o_ref_internal, o_channel_sel}, 32'h2);
    apb(0, OES_REG_OFS_Y, 0);
    chk(rd, 32'h0);
    finish_test();
  end
endmodule : oes_scaler_tb
